// File: hw/twsp_top.sv
/*
 * three-wire serial port: wishbone register file, transfer engine, pin control.
 * assumes a classic wishbone master on sys_clk and external pad logic that
 * resolves each two-way pin from its active-low output enable.
 */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ns

module twsp_top import twsp_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [17:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serial_clk_pin_i,
    output logic serial_clk_pin_o,
    output logic serial_clk_pin_oe_n,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_oe_n
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    twsp_state_e st_q;
    twsp_state_e st_d;
    logic unit_enable_q;
    logic txrx_mode_sel_q;
    logic first_bit_sel_q;
    logic clk_polarity_sel_q;
    logic data_phase_sel_q;
    logic [2:0] count_clk_sel_q;
    logic [7:0] txbuf_q;
    logic [7:0] sr_q;
    logic [7:0] sr_d;
    logic [2:0] bit_cnt_q;
    logic [2:0] bit_cnt_d;
    logic out_bit_q;
    logic out_bit_d;
    logic sck_q;
    logic sck_d;
    logic [1:0] samp_dly_q;
    logic so_q;
    logic sck_oe_n_q;
    logic so_oe_n_q;
    logic ack_q;
    logic [31:0] dat_q;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    function automatic logic idx_hit(input logic [15:0] idx, input logic [15:0] reg_idx);
        return idx == reg_idx;
    endfunction : idx_hit

    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire [15:0] word_idx = wb_adr_i[17:2];
    wire wr_lo = bus_req & wb_we_i & wb_sel_i[0];
    wire mode_wr = wr_lo & idx_hit(word_idx, IDX_MODE);
    wire clk_wr = wr_lo & idx_hit(word_idx, IDX_CLKSEL);
    wire txb_wr = wr_lo & idx_hit(word_idx, IDX_TXBUF);
    wire sr_rd = bus_req & ~wb_we_i & idx_hit(word_idx, IDX_SHIFT);
    wire comm_active_flag = (st_q == ST_SHIFT);

    wire [7:0] mode_rd = {unit_enable_q, txrx_mode_sel_q, 1'b0, first_bit_sel_q,
                          3'h0, comm_active_flag};
    wire [7:0] clk_rd = {3'h0, clk_polarity_sel_q, data_phase_sel_q, count_clk_sel_q};
    wire [7:0] rd_mux = idx_hit(word_idx, IDX_MODE) ? mode_rd :
                        idx_hit(word_idx, IDX_CLKSEL) ? clk_rd :
                        idx_hit(word_idx, IDX_TXBUF) ? txbuf_q :
                        idx_hit(word_idx, IDX_SHIFT) ? sr_q : 8'h00;

    // ----------------------------------------------------------------
    // transfer triggers and clock events
    // ----------------------------------------------------------------
    wire tx_start = txb_wr & unit_enable_q & txrx_mode_sel_q & ~comm_active_flag;
    wire rx_start = sr_rd & unit_enable_q & ~txrx_mode_sel_q & ~comm_active_flag;
    wire start = tx_start | rx_start;
    wire ext_clk = (count_clk_sel_q == CKS_EXT);
    wire int_tick;
    wire ext_rise;
    wire ext_fall;
    wire si_s;

    twsp_clk_div u_div (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .run(comm_active_flag & ~ext_clk),
        .sel(count_clk_sel_q),
        .tick(int_tick)
    );

    twsp_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_pin(serial_clk_pin_i),
        .data_pin(serial_in_pin_i),
        .clk_rise(ext_rise),
        .clk_fall(ext_fall),
        .data_sync(si_s)
    );

    // leading edge leaves idle level, trailing edge returns to it
    wire int_lead = int_tick & (sck_q == clk_polarity_sel_q);
    wire int_trail = int_tick & (sck_q != clk_polarity_sel_q);
    wire ext_lead = clk_polarity_sel_q ? ext_fall : ext_rise;
    wire ext_trail = clk_polarity_sel_q ? ext_rise : ext_fall;
    wire lead_evt = comm_active_flag & (ext_clk ? ext_lead : int_lead);
    wire trail_evt = comm_active_flag & (ext_clk ? ext_trail : int_trail);
    wire sample_raw = data_phase_sel_q ? trail_evt : lead_evt;
    // own clock: sample two cycles late to cover the input synchroniser
    wire sample_evt = ext_clk ? sample_raw : samp_dly_q[1];
    wire change_evt = data_phase_sel_q ? lead_evt : trail_evt;
    wire done_evt = trail_evt & (bit_cnt_q == BIT_LAST);

    wire top_bit = first_bit_sel_q ? sr_q[0] : sr_q[7];
    // shift and change may fall on one edge at the fastest rate
    wire next_bit = first_bit_sel_q ? sr_q[1] : sr_q[6];
    wire load_top = first_bit_sel_q ? wb_dat_i[0] : wb_dat_i[7];
    wire [7:0] sr_shifted = first_bit_sel_q ? {si_s, sr_q[7:1]} : {sr_q[6:0], si_s};

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_IDLE: begin
                if (start) begin
                    st_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (done_evt) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
        if (!unit_enable_q) begin
            st_d = ST_IDLE;
        end
    end

    assign sr_d = tx_start ? wb_dat_i[7:0] : sample_evt ? sr_shifted : sr_q;
    assign bit_cnt_d = start ? 3'h0 : trail_evt ? 3'(bit_cnt_q + 3'h1) : bit_cnt_q;
    assign out_bit_d = (tx_start & ~data_phase_sel_q) ? load_top :
                       change_evt ? (sample_evt ? next_bit : top_bit) : out_bit_q;
    assign sck_d = (comm_active_flag & ~ext_clk & int_tick) ? ~sck_q :
                   comm_active_flag ? sck_q : clk_polarity_sel_q;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            unit_enable_q <= MODE_RESET[MODE_UE_BIT];
            txrx_mode_sel_q <= MODE_RESET[MODE_TXRX_BIT];
            first_bit_sel_q <= MODE_RESET[MODE_FBS_BIT];
        end else if (mode_wr) begin
            unit_enable_q <= wb_dat_i[MODE_UE_BIT];
            txrx_mode_sel_q <= wb_dat_i[MODE_TXRX_BIT];
            first_bit_sel_q <= wb_dat_i[MODE_FBS_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clk_polarity_sel_q <= CLKSEL_RESET[CLK_CKP_BIT];
            data_phase_sel_q <= CLKSEL_RESET[CLK_DAP_BIT];
            count_clk_sel_q <= CLKSEL_RESET[CLK_CKS_LSB +: 3];
        end else if (clk_wr) begin
            clk_polarity_sel_q <= wb_dat_i[CLK_CKP_BIT];
            data_phase_sel_q <= wb_dat_i[CLK_DAP_BIT];
            count_clk_sel_q <= wb_dat_i[CLK_CKS_LSB +: 3];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (txb_wr) begin
            txbuf_q <= wb_dat_i[7:0];
        end
        sr_q <= sr_d;
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            bit_cnt_q <= 3'h0;
            out_bit_q <= 1'b0;
            sck_q <= CLKSEL_RESET[CLK_CKP_BIT];
            samp_dly_q <= 2'h0;
        end else begin
            st_q <= st_d;
            bit_cnt_q <= bit_cnt_d;
            out_bit_q <= out_bit_d;
            sck_q <= sck_d;
            samp_dly_q <= {samp_dly_q[0], sample_raw & ~ext_clk};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            so_q <= 1'b0;
            sck_oe_n_q <= 1'b1;
            so_oe_n_q <= 1'b1;
        end else begin
            so_q <= txrx_mode_sel_q & out_bit_q;
            sck_oe_n_q <= ~(unit_enable_q & ~ext_clk);
            so_oe_n_q <= ~unit_enable_q;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= bus_req;
            if (bus_req && !wb_we_i) begin
                dat_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign serial_clk_pin_o = sck_q;
    assign serial_clk_pin_oe_n = sck_oe_n_q;
    assign serial_out_pin_o = so_q;
    assign serial_out_pin_oe_n = so_oe_n_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic [3:0] samp_cnt_q;
    always_ff @(posedge sys_clk) begin
        if (!rst_n || start) begin
            samp_cnt_q <= 4'h0;
        end else if (sample_evt) begin
            samp_cnt_q <= 4'(samp_cnt_q + 4'h1);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    AST_EIGHT_BITS: assert property (
        done_evt ##1 !start [*2] |=> samp_cnt_q == BITS_PER_UNIT)
        else $error("transfer ended without eight samples");
    AST_MSB_ORDER: assert property (
        (change_evt && !first_bit_sel_q) |=> out_bit_q == sr_q[7])
        else $error("msb-first output bit wrong");
    AST_TX_START: assert property (
        tx_start |=> comm_active_flag && sr_q == $past(wb_dat_i[7:0]))
        else $error("transmit write did not start transfer");
    AST_RX_START: assert property (
        (txb_wr && !txrx_mode_sel_q && !comm_active_flag && !sr_rd) |=> !comm_active_flag)
        else $error("receive mode started on buffer write");
    AST_RX_TRIG: assert property (
        rx_start |=> comm_active_flag ##0 wb_ack_o)
        else $error("shift register read did not start reception");
    AST_SAMPLE_IN: assert property (
        (sample_evt && !first_bit_sel_q) |=> sr_q[0] == $past(si_s))
        else $error("input bit not shifted in");
    AST_SO_LOW: assert property (
        !txrx_mode_sel_q |=> !serial_out_pin_o)
        else $error("serial out not low in receive mode");
    AST_RELEASE: assert property (
        !unit_enable_q |=> serial_clk_pin_oe_n && serial_out_pin_oe_n)
        else $error("pins driven while disabled");
    AST_FLAG_RO: assert property (
        (mode_wr && !comm_active_flag && !start) |=> !comm_active_flag)
        else $error("mode write set active flag");
    AST_DISABLE: assert property (
        !unit_enable_q |=> !comm_active_flag)
        else $error("active flag survived disable");
    AST_RESET_VAL: assert property (
        $past(!rst_n) |-> !unit_enable_q && !txrx_mode_sel_q && !first_bit_sel_q)
        else $error("mode register reset value wrong");
    AST_CLK_RESET: assert property (
        $past(!rst_n) |-> clk_polarity_sel_q && !data_phase_sel_q && count_clk_sel_q == 3'h0)
        else $error("clock select reset value wrong");
    AST_DONE_STOP: assert property (
        (done_evt && unit_enable_q) |=> !comm_active_flag ##1 $stable(sr_q))
        else $error("transfer did not stop after eighth bit");
    AST_IDLE_LEVEL: assert property (
        (!comm_active_flag && !clk_wr) |=>
            serial_clk_pin_o == clk_polarity_sel_q)
        else $error("serial clock not at idle level");
    AST_BUS_ACK: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("wishbone ack not a single pulse");

    COV_TX_DONE: cover property (tx_start ##[1:1000] done_evt);
    COV_RX_DONE: cover property (rx_start ##[1:1000] done_evt);
    COV_EXT_CLK: cover property (ext_clk && done_evt);
    COV_LSB_PHASE: cover property (first_bit_sel_q && data_phase_sel_q && done_evt);

endmodule : twsp_top

// File: common/twsp_pkg.sv
/*
 * constants for the three-wire serial port: register indices, field positions,
 * reset values and transfer counts.
 * assumes a 10 MHz system clock and a classic wishbone slave with 32-bit data.
 */
package twsp_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_MODE = 16'hffb0;
    localparam logic [15:0] IDX_CLKSEL = 16'hffb1;
    localparam logic [15:0] IDX_TXBUF = 16'hffb2;
    localparam logic [15:0] IDX_SHIFT = 16'hffb3;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MODE_UE_BIT = 7;
    localparam int MODE_TXRX_BIT = 6;
    localparam int MODE_FBS_BIT = 4;
    localparam int MODE_ACT_BIT = 0;
    localparam int CLK_CKP_BIT = 4;
    localparam int CLK_DAP_BIT = 3;
    localparam int CLK_CKS_LSB = 0;

    // ----------------------------------------------------------------
    // reset values and codes
    // ----------------------------------------------------------------
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CLKSEL_RESET = 8'h10;
    localparam logic [2:0] CKS_EXT = 3'h7;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [3:0] BITS_PER_UNIT = 4'h8;
    localparam int SYS_CLK_NS = 100;

    typedef enum logic {ST_IDLE, ST_SHIFT} twsp_state_e;

endpackage : twsp_pkg

// File: hw/twsp_pin_sync.sv
/*
 * two-flop synchronisers for the serial clock and serial input pins, with
 * edge detection on the synchronised clock.
 * assumes pins are asynchronous to sys_clk and slower than sys_clk / 4.
 */
`timescale 1ns/1ns
module twsp_pin_sync (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_pin,
    input wire logic data_pin,
    output logic clk_rise,
    output logic clk_fall,
    output logic data_sync
);
    logic [1:0] clk_meta_q;
    logic [1:0] data_meta_q;
    logic clk_prev_q;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clk_meta_q <= 2'h0;
            data_meta_q <= 2'h0;
            clk_prev_q <= 1'b0;
        end else begin
            clk_meta_q <= {clk_meta_q[0], clk_pin};
            data_meta_q <= {data_meta_q[0], data_pin};
            clk_prev_q <= clk_meta_q[1];
        end
    end

    assign clk_rise = clk_meta_q[1] & ~clk_prev_q;
    assign clk_fall = ~clk_meta_q[1] & clk_prev_q;
    assign data_sync = data_meta_q[1];

endmodule : twsp_pin_sync

// File: hw/twsp_clk_div.sv
/*
 * serial clock divider: one-cycle tick every half period of sys_clk / 2^(sel+2).
 * assumes run is low between transfers so each transfer starts from phase zero.
 */
`timescale 1ns/1ns
module twsp_clk_div (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] half_mask;

    // ----------------------------------------------------------------
    // half-period mask
    // ----------------------------------------------------------------
    function automatic logic [7:0] half_mask_f(input logic [2:0] s);
        logic [8:0] full;
        full = 9'h002 << s;
        return 8'(full - 9'h001);
    endfunction : half_mask_f

    assign half_mask = half_mask_f(sel);
    assign tick = run & ((cnt_q & half_mask) == half_mask);
    assign cnt_d = run ? 8'(cnt_q + 8'h01) : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : twsp_clk_div

// File: verif/twsp_peer.sv
/*
 * far-side model: a clocked serial peripheral that shifts a byte out on si
 * and captures the byte seen on the data line from the port.
 * assumes the bench arms it before each frame and sets ckp and dap to match.
 */
`timescale 1ns/1ns
module twsp_peer (
    input wire logic arm,
    input wire logic clk_line,
    input wire logic so_line,
    input wire logic ckp,
    input wire logic dap,
    input wire logic ext_run,
    input wire logic [7:0] tx_byte,
    output logic si,
    output logic ext_clk,
    output logic [7:0] rx_byte,
    output int n_edges
);
    int idx;
    logic tgl;

    initial tgl = 1'b0;

    // link clock stands at its idle level outside frames
    assign ext_clk = ckp ^ tgl;
    // msb first from the peer; a fixed level, the inverse of tx_byte bit 0, outside the frame
    assign si = (arm && idx >= 0 && idx < 8) ? tx_byte[7 - idx] : ~tx_byte[0];

    always @(posedge arm) begin
        idx = dap ? -1 : 0;
        rx_byte = 8'h00;
        n_edges = 0;
    end

    // leading edge leaves the idle level; phase picks sample or change
    always @(posedge clk_line or negedge clk_line) begin
        if (arm) begin
            n_edges = n_edges + 1;
            if ((clk_line !== ckp) ^ dap) begin
                rx_byte = {rx_byte[6:0], so_line};
            end else begin
                idx = idx + 1;
            end
        end
    end

    // external serial clock, 800 ns period, 8 periods per frame
    always begin
        wait (ext_run);
        #137;
        repeat (16) begin
            #400;
            tgl = ~tgl;
        end
        wait (!ext_run);
    end
endmodule : twsp_peer

// File: verif/twsp_top_tb.sv
/*
 * self-checking bench for twsp_top: wishbone tasks, random and corner frames.
 * assumes the peer model twsp_peer and the design package twsp_pkg.
 */
`timescale 1ns/1ns
module twsp_top_tb import twsp_pkg::*;;
    logic sys_clk, rst_n, cyc, stb, we, arm, ckp, dap, ext_run, si, ext_clk;
    logic clk_o, clk_oe_n, so_o, so_oe_n, wb_ack_o, prev_clk;
    logic [17:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, wb_dat_o, seed;
    logic [7:0] peer_tx, peer_rx;
    int peer_edges, n_mismatch, check_count, hcnt, half;
    wire clk_line = clk_oe_n ? ext_clk : clk_o;
    wire so_line = so_oe_n ? 1'b1 : so_o;

    twsp_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .serial_clk_pin_i(clk_line), .serial_clk_pin_o(clk_o),
        .serial_clk_pin_oe_n(clk_oe_n), .serial_in_pin_i(si), .serial_out_pin_o(so_o),
        .serial_out_pin_oe_n(so_oe_n));
    twsp_peer peer (.arm(arm), .clk_line(clk_line), .so_line(so_line), .ckp(ckp), .dap(dap),
        .ext_run(ext_run), .tx_byte(peer_tx), .si(si), .ext_clk(ext_clk), .rx_byte(peer_rx),
        .n_edges(peer_edges));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // half period of the driven serial clock, in system cycles
    always @(posedge sys_clk) begin
        prev_clk <= clk_o;
        hcnt <= (clk_o !== prev_clk) ? 1 : hcnt + 1;
        if (clk_o !== prev_clk) half <= hcnt;
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [7:0] ord(input logic [7:0] v, input logic lsb);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) r[i] = v[7 - i];
        return lsb ? r : v;
    endfunction : ord

    task automatic summarize();
        $display("mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
                      output logic [7:0] r);
        int n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= 4'h1;
        dat <= {24'h000000, d};
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 64);
        if (n >= 64) begin
            n_mismatch++;
            summarize();
        end
        r = wb_dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wait_idle();
        logic [7:0] r;
        int n = 0;
        do begin
            wb(1'b0, IDX_MODE, 8'h00, r);
            n++;
        end while (r[MODE_ACT_BIT] !== 1'b0 && n < 2000);
        if (n >= 2000) begin
            n_mismatch++;
            summarize();
        end
    endtask : wait_idle

    // ----------------------------------------------------------------
    // one frame against the peer
    // ----------------------------------------------------------------
    task automatic frame(input logic txrx, input logic lsb, input logic cp, input logic dp,
                         input logic [2:0] cs);
        logic [7:0] d, r;
        seed = lfsr(seed);
        d = seed[7:0];
        wb(1'b1, IDX_MODE, {1'b1, txrx, 1'b0, lsb, 4'h0}, r);
        wb(1'b1, IDX_CLKSEL, {3'h0, cp, dp, cs}, r);
        @(posedge sys_clk);
        ckp <= cp;
        dap <= dp;
        peer_tx <= seed[15:8];
        repeat (2) @(posedge sys_clk);
        chk({clk_oe_n, clk_line}, {cs == CKS_EXT, cp});
        arm <= 1'b1;
        wb(txrx, txrx ? IDX_TXBUF : IDX_SHIFT, d, r);
        ext_run <= (cs == CKS_EXT);
        wb(1'b0, IDX_MODE, 8'h00, r);
        chk(r, {1'b1, txrx, 1'b0, lsb, 4'h1});
        wait_idle();
        chk(peer_edges, 16);
        if (cs != CKS_EXT) begin
            chk(peer_rx, txrx ? ord(d, lsb) : 8'h00);
            chk(half, 32'h2 << cs);
        end
        chk(clk_line, cp);
        ext_run <= 1'b0;
        wb(1'b0, IDX_SHIFT, 8'h00, r);
        chk(r, ord(peer_tx, lsb));
        arm <= 1'b0;
        // the read above restarts reception; stop it by disabling the unit
        if (!txrx) begin
            wb(1'b1, IDX_MODE, {1'b0, txrx, 1'b0, lsb, 4'h0}, r);
            wait_idle();
        end
    endtask : frame

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] r;
        {rst_n, cyc, stb, we, arm, ext_run, dap} = '0;
        adr = '0;
        sel = '0;
        dat = '0;
        ckp = 1'b1;
        peer_tx = 8'h00;
        seed = 32'hf09f;
        {n_mismatch, check_count, hcnt, half} = '0;
        prev_clk = 1'b1;
        repeat (16) @(posedge sys_clk);
        chk({clk_oe_n, so_oe_n}, 2'b11);
        rst_n <= 1'b1;
        wb(1'b0, IDX_MODE, 8'h00, r);
        chk(r, MODE_RESET);
        wb(1'b0, IDX_CLKSEL, 8'h00, r);
        chk(r, CLKSEL_RESET);
        wb(1'b0, 16'h0000, 8'h00, r);
        chk(r, 8'h00);
        wb(1'b1, IDX_MODE, 8'hd1, r);
        wb(1'b0, IDX_MODE, 8'h00, r);
        chk(r, 8'hd0);
        repeat (2) @(posedge sys_clk);
        chk({clk_oe_n, so_oe_n}, 2'b00);
        for (int i = 0; i < 8; i++) frame(1'b1, i[0], i[2], i[1], 3'(i % 7));
        frame(1'b0, 1'b1, 1'b0, 1'b1, 3'h2);
        frame(1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
        frame(1'b1, 1'b0, 1'b1, 1'b1, CKS_EXT);
        frame(1'b0, 1'b1, 1'b0, 1'b0, CKS_EXT);
        repeat (6) begin
            seed = lfsr(seed);
            frame(seed[3], seed[4], seed[5], seed[6], seed[9:7]);
        end
        // disable in mid-frame
        wb(1'b1, IDX_MODE, 8'hc0, r);
        wb(1'b1, IDX_CLKSEL, 8'h06, r);
        wb(1'b1, IDX_TXBUF, 8'ha5, r);
        repeat (20) @(posedge sys_clk);
        wb(1'b1, IDX_MODE, 8'h40, r);
        wb(1'b0, IDX_MODE, 8'h00, r);
        chk(r, 8'h40);
        repeat (2) @(posedge sys_clk);
        chk({clk_oe_n, so_oe_n}, 2'b11);
        summarize();
    end
endmodule : twsp_top_tb
